// >>> rtl/ua_pkg.sv
// Package of register map, field layout, states and rate table for the UART channel
package ua_pkg;

  // ----------------------------------------------------------------
  // Clock and bit timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ_DEF = 40_000_000;
  localparam int unsigned OVS        = 16;
  localparam int unsigned RATE_N     = 10;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] A_CTRL   = 5'h00;
  localparam logic [4:0] A_CMD    = 5'h04;
  localparam logic [4:0] A_TXDATA = 5'h08;
  localparam logic [4:0] A_RXDATA = 5'h0c;
  localparam logic [4:0] A_STAT   = 5'h10;
  localparam logic [4:0] A_ERR    = 5'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_RATE = 0;
  localparam int CTRL_TWO  = 4;
  localparam int CTRL_PAR  = 5;
  localparam int CMD_LEN   = 0;
  localparam int CMD_RX    = 8;
  localparam int CMD_TX    = 9;
  localparam int CMD_ABORT = 10;
  localparam int ST_CNT    = 0;
  localparam int ST_TXRDY  = 8;
  localparam int ST_RXVLD  = 9;
  localparam int ST_RXBUSY = 10;
  localparam int ST_CFGERR = 11;
  localparam int ST_RATEOK = 12;
  localparam int ST_TXBUSY = 13;
  localparam int ERR_PAR   = 1;
  localparam int ERR_FRM   = 2;
  localparam int ERR_NOISE = 3;
  localparam int ERR_OVR   = 4;

  // ----------------------------------------------------------------
  // Encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ODD  = 2'h1;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic [3:0] RATE_RST = 4'h0;
  localparam logic [4:0] ERR_RST  = 5'h00;

  typedef enum logic [4:0] {
    RXS_IDLE  = 5'h01,
    RXS_START = 5'h02,
    RXS_DATA  = 5'h04,
    RXS_PAR   = 5'h08,
    RXS_STOP  = 5'h10
  } ua_rx_st_t;

  typedef enum logic [4:0] {
    TXS_IDLE  = 5'h01,
    TXS_START = 5'h02,
    TXS_DATA  = 5'h04,
    TXS_PAR   = 5'h08,
    TXS_STOP  = 5'h10
  } ua_tx_st_t;

  // Bit rate of a select code; zero marks an unsupported code
  function automatic int unsigned rate_bps(logic [3:0] sel);
    case (sel)
      4'h0:    return 300;
      4'h1:    return 600;
      4'h2:    return 1200;
      4'h3:    return 2400;
      4'h4:    return 4800;
      4'h5:    return 9600;
      4'h6:    return 19200;
      4'h7:    return 38400;
      4'h8:    return 57600;
      4'h9:    return 115200;
      default: return 0;
    endcase
  endfunction

  // Rounded divisor from the clock to the oversampling tick
  function automatic logic [15:0] rate_div(int unsigned clk_hz, logic [3:0] sel);
    int unsigned bps;
    bps = rate_bps(sel);
    if (bps == 0) begin
      return 16'h0001;
    end
    return 16'((clk_hz + bps * OVS / 2) / (bps * OVS));
  endfunction

endpackage

// >>> rtl/ua_rate_gen.sv
// Divider producing the sixteen-times oversampling enable pulse
`timescale 1ns/1ps
`default_nettype none
module ua_rate_gen
  import ua_pkg::*;
#(
  parameter int unsigned CLK_HZ = CLK_HZ_DEF
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Tick link to the core
  ua_tick_if.gen    tk
);

  logic [15:0] cnt_q;
  logic [3:0]  rate_q;
  logic        tick_q;

  // A rate change restarts the count so the new rate takes hold at once
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q  <= 16'h0000;
      rate_q <= RATE_RST;
      tick_q <= 1'b0;
    end else begin
      rate_q <= tk.rate;
      tick_q <= 1'b0;
      if (!tk.run || rate_q != tk.rate) begin
        cnt_q <= 16'h0000;
      end else if (cnt_q == rate_div(CLK_HZ, rate_q) - 16'h0001) begin
        cnt_q  <= 16'h0000;
        tick_q <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end

  assign tk.tick = tick_q;

endmodule
`default_nettype wire

// >>> rtl/ua_tick_if.sv
// Interface carrying rate select and oversampling tick between core and divider
`timescale 1ns/1ps
`default_nettype none
interface ua_tick_if;
  logic [3:0] rate;
  logic       run;
  logic       tick;
  modport ctl (output rate, output run, input tick);
  modport gen (input rate, input run, output tick);
endinterface
`default_nettype wire

// >>> rtl/ua_uart.sv
// UART channel core with Avalon-MM register access
//
// The address map and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Ten bit rates, 300 to 115200, one rate for both directions.
// - Divisors computed for the system clock, rounded to nearest.
// - One stop bit by default, two when configured.
// - Two stop bits together with parity is refused.
// - Parity none, odd or even; default none.
// - Rate changes at run time; nothing moves until a rate is set.
// - Receive on the receive pin, transmit on the transmit pin.
// - Starting a receive or transmit request clears the error code.
// - Transmit ready once every byte is written to the holding stage.
// - Received count reported; request ends when count equals length.
// - Errors accumulate: parity 0x02, framing 0x04, noise 0x08, overrun 0x10.
// - Reading the error code returns it and clears it.
// - Abort stops reception; count keeps bytes received before it.
// - Start bit, eight data bits, then optional parity and one stop, or two stops.
// - Bad stop bit flags framing error and resynchronises.
// - A request moves at most 255 bytes each way.
module ua_uart
  import ua_pkg::*;
#(
  parameter int unsigned CLK_HZ = CLK_HZ_DEF
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Avalon-MM slave
  input  wire logic [4:0]  address_in,
  input  wire logic        read_in,
  input  wire logic        write_in,
  input  wire logic [31:0] writedata_in,
  output logic [31:0]      readdata_out,
  output logic             waitrequest_out,
  // Serial line
  input  wire logic        rxd_in,
  output logic             txd_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  ua_tick_if tk ();

  logic        waitreq_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_mux;
  logic        req;
  logic        acc;
  logic        stall;
  logic        wr_ctrl;
  logic        wr_cmd;
  logic        wr_txd;
  logic        rd_rxd;
  logic        rd_err;
  logic        cfg_ok;
  logic        rx_go;
  logic        tx_go;
  logic        abort_go;
  logic [7:0]  cmd_len;

  logic [3:0]  rate_q;
  logic        rate_vld_q;
  logic        two_q;
  logic [1:0]  par_q;
  logic        cfg_err_q;
  logic [4:0]  err_q;
  logic [4:0]  err_set;

  ua_rx_st_t   rx_st_q;
  logic [3:0]  rx_sub_q;
  logic [2:0]  rx_bit_q;
  logic [7:0]  rx_sh_q;
  logic        rx_prev_q;
  logic [1:0]  rx_smp_q;
  logic        rx_par_q;
  logic        rx_stop2_q;
  logic        rx_vld_q;
  logic [7:0]  rx_dat_q;
  logic        rx_busy_q;
  logic [7:0]  rx_len_q;
  logic [7:0]  rx_cnt_q;
  logic [7:0]  rx_cnt_nx;
  logic        rx_mid;
  logic        rx_maj;
  logic        rx_noisy;
  logic        deliver;

  ua_tx_st_t   tx_st_q;
  logic [3:0]  tx_sub_q;
  logic [2:0]  tx_bit_q;
  logic [7:0]  tx_sh_q;
  logic [7:0]  tx_hold_q;
  logic        tx_full_q;
  logic [7:0]  tx_left_q;
  logic        tx_par_q;
  logic        tx_stop2_q;
  logic        txd_q;
  logic        tx_end;
  logic        tx_last;
  logic        tx_load;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  // A data write waits while the holding byte is still unsent
  assign req      = read_in | write_in;
  assign acc      = req & ~waitreq_q;
  assign stall    = write_in & (address_in == A_TXDATA) & tx_full_q & (tx_left_q != 8'h00);
  assign wr_ctrl  = acc & write_in & (address_in == A_CTRL);
  assign wr_cmd   = acc & write_in & (address_in == A_CMD);
  assign wr_txd   = acc & write_in & (address_in == A_TXDATA);
  assign rd_rxd   = acc & read_in & (address_in == A_RXDATA);
  assign rd_err   = acc & read_in & (address_in == A_ERR);
  assign cmd_len  = writedata_in[CMD_LEN +: 8];
  assign rx_go    = wr_cmd & writedata_in[CMD_RX] & (cmd_len != 8'h00) & rate_vld_q;
  assign tx_go    = wr_cmd & writedata_in[CMD_TX] & (cmd_len != 8'h00) & rate_vld_q;
  assign abort_go = wr_cmd & writedata_in[CMD_ABORT];

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (address_in)
      A_CTRL: begin
        rd_mux[CTRL_RATE +: 4] = rate_q;
        rd_mux[CTRL_TWO]       = two_q;
        rd_mux[CTRL_PAR +: 2]  = par_q;
      end
      A_RXDATA: rd_mux[7:0] = rx_dat_q;
      A_STAT: begin
        rd_mux[ST_CNT +: 8] = rx_cnt_q;
        rd_mux[ST_TXRDY]    = (tx_left_q == 8'h00);
        rd_mux[ST_RXVLD]    = rx_vld_q;
        rd_mux[ST_RXBUSY]   = rx_busy_q;
        rd_mux[ST_CFGERR]   = cfg_err_q;
        rd_mux[ST_RATEOK]   = rate_vld_q;
        rd_mux[ST_TXBUSY]   = (tx_st_q != TXS_IDLE) | tx_full_q;
      end
      A_ERR:   rd_mux[4:0] = err_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // One wait state per access, more while a data write is stalled; read data are caught as waitrequest falls
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      waitreq_q <= 1'b1;
      rdata_q   <= 32'h0000_0000;
    end else if (req & waitreq_q & ~stall) begin
      waitreq_q <= 1'b0;
      rdata_q   <= read_in ? rd_mux : 32'h0000_0000;
    end else begin
      waitreq_q <= 1'b1;
    end
  end

  assign waitrequest_out = waitreq_q;
  assign readdata_out    = rdata_q;

  // ----------------------------------------------------------------
  // Configuration
  // ----------------------------------------------------------------
  // Changing format mid-character corrupts that character only
  assign cfg_ok = (rate_bps(writedata_in[CTRL_RATE +: 4]) != 0)
                & ~(writedata_in[CTRL_TWO] & (writedata_in[CTRL_PAR +: 2] != PAR_NONE))
                & (writedata_in[CTRL_PAR +: 2] != 2'h3);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rate_q     <= RATE_RST;
      rate_vld_q <= 1'b0;
      two_q      <= 1'b0;
      par_q      <= PAR_NONE;
      cfg_err_q  <= 1'b0;
    end else if (wr_ctrl) begin
      if (cfg_ok) begin
        rate_q     <= writedata_in[CTRL_RATE +: 4];
        rate_vld_q <= 1'b1;
        two_q      <= writedata_in[CTRL_TWO];
        par_q      <= writedata_in[CTRL_PAR +: 2];
        cfg_err_q  <= 1'b0;
      end else begin
        cfg_err_q  <= 1'b1;
      end
    end
  end

  assign tk.rate = rate_q;
  assign tk.run  = rate_vld_q;

  ua_rate_gen #(
    .CLK_HZ (CLK_HZ)
  ) u_rate (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .tk     (tk)
  );

  // ----------------------------------------------------------------
  // Error code
  // ----------------------------------------------------------------
  // Only bits already returned are cleared, so a new error is never lost
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      err_q <= ERR_RST;
    end else if (rx_go | tx_go) begin
      err_q <= err_set;
    end else if (rd_err) begin
      err_q <= (err_q & ~rdata_q[4:0]) | err_set;
    end else begin
      err_q <= err_q | err_set;
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  assign rx_mid   = tk.tick & (rx_sub_q == 4'h9) & (rx_st_q != RXS_IDLE);
  assign rx_maj   = (rx_smp_q[0] & rx_smp_q[1]) | (rx_smp_q[0] & rxd_in)
                  | (rx_smp_q[1] & rxd_in);
  assign rx_noisy = ~((rx_smp_q[0] == rx_smp_q[1]) & (rx_smp_q[1] == rxd_in));
  assign deliver  = rx_mid & (rx_st_q == RXS_STOP) & rx_maj & (~two_q | rx_stop2_q)
                  & rx_busy_q;
  assign rx_cnt_nx = rx_cnt_q + 8'h01;

  always_comb begin
    err_set            = 5'h00;
    err_set[ERR_PAR]   = rx_mid & rx_busy_q & (rx_st_q == RXS_PAR)
                       & (rx_par_q ^ rx_maj ^ (par_q == PAR_ODD));
    err_set[ERR_FRM]   = rx_mid & rx_busy_q & (rx_st_q == RXS_STOP) & ~rx_maj;
    err_set[ERR_NOISE] = rx_mid & rx_busy_q & rx_noisy;
    err_set[ERR_OVR]   = deliver & rx_vld_q & ~rd_rxd;
  end

  // Three samples around mid-bit, decided by majority
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_st_q    <= RXS_IDLE;
      rx_sub_q   <= 4'h0;
      rx_bit_q   <= 3'h0;
      rx_sh_q    <= 8'h00;
      rx_prev_q  <= 1'b1;
      rx_smp_q   <= 2'h3;
      rx_par_q   <= 1'b0;
      rx_stop2_q <= 1'b0;
    end else if (abort_go) begin
      rx_st_q <= RXS_IDLE;
    end else if (tk.tick) begin
      rx_prev_q <= rxd_in;
      rx_sub_q  <= rx_sub_q + 4'h1;
      if (rx_sub_q == 4'h7) begin
        rx_smp_q[0] <= rxd_in;
      end
      if (rx_sub_q == 4'h8) begin
        rx_smp_q[1] <= rxd_in;
      end
      case (rx_st_q)
        RXS_IDLE: begin
          if (rx_prev_q & ~rxd_in) begin
            rx_st_q    <= RXS_START;
            rx_sub_q   <= 4'h0;
            rx_par_q   <= 1'b0;
            rx_stop2_q <= 1'b0;
          end
        end
        RXS_START: begin
          if (rx_mid) begin
            rx_st_q  <= rx_maj ? RXS_IDLE : RXS_DATA;
            rx_bit_q <= 3'h0;
          end
        end
        RXS_DATA: begin
          if (rx_mid) begin
            rx_sh_q  <= {rx_maj, rx_sh_q[7:1]};
            rx_par_q <= rx_par_q ^ rx_maj;
            rx_bit_q <= rx_bit_q + 3'h1;
            if (rx_bit_q == 3'h7) begin
              rx_st_q <= (par_q != PAR_NONE) ? RXS_PAR : RXS_STOP;
            end
          end
        end
        RXS_PAR: begin
          if (rx_mid) begin
            rx_st_q <= RXS_STOP;
          end
        end
        RXS_STOP: begin
          if (rx_mid) begin
            if (!rx_maj) begin
              rx_st_q <= RXS_IDLE;
            end else if (two_q & ~rx_stop2_q) begin
              rx_stop2_q <= 1'b1;
            end else begin
              rx_st_q <= RXS_IDLE;
            end
          end
        end
        default: rx_st_q <= RXS_IDLE;
      endcase
    end
  end

  // Holding byte; on overrun the older byte is kept
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_vld_q <= 1'b0;
      rx_dat_q <= 8'h00;
    end else if (deliver & (~rx_vld_q | rd_rxd)) begin
      rx_vld_q <= 1'b1;
      rx_dat_q <= rx_sh_q;
    end else if (rd_rxd) begin
      rx_vld_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_busy_q <= 1'b0;
      rx_len_q  <= 8'h00;
      rx_cnt_q  <= 8'h00;
    end else begin
      if (rx_go & ~abort_go) begin
        rx_len_q <= cmd_len;
        rx_cnt_q <= 8'h00;
      end else if (deliver) begin
        rx_cnt_q <= rx_cnt_nx;
      end
      if (abort_go) begin
        rx_busy_q <= 1'b0;
      end else if (rx_go) begin
        rx_busy_q <= 1'b1;
      end else if (deliver & (rx_cnt_nx == rx_len_q)) begin
        rx_busy_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  assign tx_end  = tk.tick & (tx_sub_q == 4'hf);
  assign tx_last = (tx_st_q == TXS_STOP) & (~two_q | tx_stop2_q);
  assign tx_load = tk.tick & tx_full_q & ((tx_st_q == TXS_IDLE) | (tx_end & tx_last));

  // Hand-off counter: ready as soon as the last byte sits in the holding stage
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_left_q <= 8'h00;
      tx_hold_q <= 8'h00;
      tx_full_q <= 1'b0;
    end else begin
      if (tx_go) begin
        tx_left_q <= cmd_len;
      end else if (wr_txd & (tx_left_q != 8'h00)) begin
        tx_left_q <= tx_left_q - 8'h01;
        tx_hold_q <= writedata_in[7:0];
      end
      if (wr_txd & (tx_left_q != 8'h00)) begin
        tx_full_q <= 1'b1;
      end else if (tx_load) begin
        tx_full_q <= 1'b0;
      end
    end
  end

  // Back-to-back characters leave no idle gap on the line
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_st_q    <= TXS_IDLE;
      tx_sub_q   <= 4'h0;
      tx_bit_q   <= 3'h0;
      tx_sh_q    <= 8'h00;
      tx_par_q   <= 1'b0;
      tx_stop2_q <= 1'b0;
      txd_q      <= 1'b1;
    end else if (tx_load) begin
      tx_st_q    <= TXS_START;
      tx_sub_q   <= 4'h0;
      tx_sh_q    <= tx_hold_q;
      tx_par_q   <= ^tx_hold_q;
      tx_stop2_q <= 1'b0;
      txd_q      <= 1'b0;
    end else if (tk.tick & (tx_st_q != TXS_IDLE)) begin
      tx_sub_q <= tx_sub_q + 4'h1;
      if (tx_end) begin
        case (tx_st_q)
          TXS_START: begin
            tx_st_q  <= TXS_DATA;
            tx_bit_q <= 3'h0;
            txd_q    <= tx_sh_q[0];
          end
          TXS_DATA: begin
            if (tx_bit_q == 3'h7) begin
              tx_st_q <= (par_q != PAR_NONE) ? TXS_PAR : TXS_STOP;
              txd_q   <= (par_q != PAR_NONE) ? (tx_par_q ^ (par_q == PAR_ODD)) : 1'b1;
            end else begin
              tx_bit_q <= tx_bit_q + 3'h1;
              tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
              txd_q    <= tx_sh_q[1];
            end
          end
          TXS_PAR: begin
            tx_st_q <= TXS_STOP;
            txd_q   <= 1'b1;
          end
          TXS_STOP: begin
            if (!tx_last) begin
              tx_stop2_q <= 1'b1;
            end else begin
              tx_st_q <= TXS_IDLE;
            end
          end
          default: begin
            tx_st_q <= TXS_IDLE;
            txd_q   <= 1'b1;
          end
        endcase
      end
    end
  end

  assign txd_out = txd_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_abort;
    abort_go;
  endsequence

  sequence s_rx_held;
    !rx_busy_q && (rx_cnt_q == $past(rx_cnt_q));
  endsequence

  sequence s_last_byte;
    deliver && (rx_cnt_nx == rx_len_q);
  endsequence

  err_req_clear_a : assert property ((rx_go || tx_go) && (err_set == 5'h00) |=> err_q == 5'h00)
    else $error("error code not cleared by a new request");
  err_read_clr_a : assert property (rd_err && (err_set == 5'h00) |=> (err_q & $past(rdata_q[4:0])) == 5'h00)
    else $error("error bits survived their read");
  cfg_legal_a : assert property (!(two_q && (par_q != PAR_NONE)))
    else $error("two stop bits combined with parity");
  tx_start_low_a : assert property (tx_load |=> (tx_st_q == TXS_START) && !txd_out)
    else $error("start bit not driven low");
  tx_stop_high_a : assert property ((tx_st_q == TXS_STOP) || (tx_st_q == TXS_IDLE) |-> txd_out)
    else $error("line not high in stop or idle");
  rx_count_end_a : assert property (s_last_byte |=> !rx_busy_q && (rx_cnt_q == $past(rx_len_q)))
    else $error("receive request did not end at its length");
  rx_abort_a : assert property (s_abort |=> s_rx_held)
    else $error("abort did not stop reception with count held");
  frame_err_a : assert property (err_set[ERR_FRM] && !rx_go && !tx_go |=> err_q[ERR_FRM])
    else $error("framing error not flagged");
  overrun_a : assert property (deliver && rx_vld_q && !rd_rxd && !rx_go && !tx_go |=> err_q[ERR_OVR])
    else $error("overrun not flagged");
  stop_two_a : assert property (tx_stop2_q && (tx_st_q == TXS_STOP) |-> two_q)
    else $error("second stop bit without two-stop setting");

endmodule
`default_nettype wire

// >>> testbench/tb.sv
// Self-checking testbench for the UART channel
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ua_pkg::*;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        read_in = 1'b0;
  logic        write_in = 1'b0;
  logic [4:0]  address_in = 5'h00;
  logic [31:0] writedata_in = 32'h0;
  logic [31:0] readdata_out;
  logic        waitrequest_out;
  logic        rxd;
  logic        txd;
  int          err_count = 0;
  int          total_checks = 0;
  logic [63:0] bus_q[$];
  logic [8:0]  ser_q[$];
  logic [63:0] nb;
  logic [7:0]  b;
  int          bps[10] = '{300, 600, 1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200};
  logic [6:0]  cf[5] = '{7'h09, 7'h29, 7'h49, 7'h18, 7'h47};
  localparam int unsigned SIM_HZ = 1843200;

  // Small clock so that 115200 divides to one clock per tick
  ua_uart #(.CLK_HZ(SIM_HZ)) u_ua_uart (.clk_in(clk_in), .rst_in(rst_in),
    .address_in(address_in), .read_in(read_in), .write_in(write_in),
    .writedata_in(writedata_in), .readdata_out(readdata_out),
    .waitrequest_out(waitrequest_out), .rxd_in(rxd), .txd_out(txd));
  ua_peer u_ua_peer (.clk_in(clk_in), .txd_in(txd), .rxd_out(rxd));

  always #12.5 clk_in = ~clk_in;

  task automatic chk(logic [31:0] e, logic [31:0] a);
    total_checks++;
    if (a !== e) begin
      err_count++;
      $display("mismatch at %0t: expected %h got %h", $time, e, a);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic wr(logic [4:0] a, logic [31:0] d);
    address_in <= a;
    writedata_in <= d;
    write_in <= 1'b1;
    do @(posedge clk_in); while (waitrequest_out !== 1'b0);
    write_in <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic rd(logic [4:0] a, logic [31:0] e, logic [31:0] m = 32'hffffffff);
    bus_q.push_back({m, e});
    address_in <= a;
    read_in <= 1'b1;
    do @(posedge clk_in); while (waitrequest_out !== 1'b0);
    read_in <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic cfg(logic [6:0] v);
    wr(A_CTRL, {25'h0, v});
    rd(A_CTRL, {25'h0, v}, 32'h7f);
    u_ua_peer.par_mode = v[6:5];
    u_ua_peer.two_stop = v[4];
    u_ua_peer.bit_clks = 16 * (SIM_HZ / (16 * bps[v[3:0]]));
  endtask

  always @(posedge clk_in) begin
    if (read_in && waitrequest_out === 1'b0) begin
      nb = bus_q.pop_front();
      chk(nb[31:0], readdata_out & nb[63:32]);
    end
  end

  always @(u_ua_peer.done) chk({23'h0, ser_q.pop_front()}, {23'h0, u_ua_peer.got});

  initial begin
    repeat (40000) @(posedge clk_in);
    err_count++;
    final_report();
  end

  initial begin
    void'($urandom(32'habad));
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    rd(5'h18, 32'h0);
    wr(A_CMD, 32'h301);
    rd(A_STAT, 32'h100, 32'h1700);
    for (int r = 0; r < 11; r++) begin
      wr(A_CTRL, r);
      rd(A_STAT, (r < 10) ? 32'h1000 : 32'h1800, 32'h1800);
    end
    for (int k = 0; k < 3; k++) begin
      wr(A_CTRL, 32'h39 + 32 * k);
      rd(A_STAT, 32'h1800, 32'h1800);
      rd(A_CTRL, 32'h09, 32'h7f);
    end
    foreach (cf[k]) begin
      cfg(cf[k]);
      wr(A_CMD, 32'h202);
      rd(A_STAT, 32'h000, 32'h100);
      for (int i = 0; i < 2; i++) begin
        b = 8'($urandom);
        ser_q.push_back({1'b0, b});
        wr(A_TXDATA, {24'h0, b});
      end
      rd(A_STAT, 32'h100, 32'h100);
      wr(A_CMD, 32'h102);
      for (int i = 0; i < 2; i++) begin
        b = 8'($urandom);
        u_ua_peer.send(b, 1'b0, 1'b0);
        rd(A_RXDATA, {24'h0, b}, 32'hff);
      end
      rd(A_STAT, 32'h2, 32'h6ff);
      rd(A_ERR, 32'h0);
    end
    cfg(7'h29);
    wr(A_CMD, 32'h103);
    u_ua_peer.send(8'h5a, 1'b1, 1'b0);
    rd(A_RXDATA, 32'h5a, 32'hff);
    u_ua_peer.send(8'h3c, 1'b0, 1'b1);
    u_ua_peer.send(8'hc3, 1'b0, 1'b0);
    rd(A_STAT, 32'h402, 32'h4ff);
    rd(A_ERR, 32'h06);
    rd(A_ERR, 32'h00);
    u_ua_peer.send(8'h96, 1'b0, 1'b0);
    rd(A_ERR, 32'h10);
    wr(A_CMD, 32'h101);
    u_ua_peer.send(8'h11, 1'b1, 1'b0);
    wr(A_CMD, 32'h103);
    rd(A_ERR, 32'h0);
    u_ua_peer.send(8'h22, 1'b0, 1'b0);
    wr(A_CMD, 32'h400);
    u_ua_peer.send(8'h33, 1'b0, 1'b0);
    rd(A_STAT, 32'h001, 32'h4ff);
    rd(A_RXDATA, 32'hc3, 32'hff);
    wr(A_CMD, 32'h101);
    u_ua_peer.spike = 1'b1;
    u_ua_peer.send(8'h44, 1'b0, 1'b0);
    u_ua_peer.spike = 1'b0;
    rd(A_RXDATA, 32'h44, 32'hff);
    rd(A_ERR, 32'h08);
    final_report();
  end
endmodule
`default_nettype wire

// >>> testbench/ua_peer.sv
// Serial peer model: drives the receive line and decodes the transmit line
`timescale 1ns/1ps
`default_nettype none
module ua_peer (
  // Clock and lines
  input  wire logic clk_in,
  input  wire logic txd_in,
  output var logic  rxd_out
);
  int         bit_clks = 16;
  logic [1:0] par_mode = 2'h0;
  logic       two_stop = 1'b0;
  logic       spike    = 1'b0;
  logic [8:0] got;
  event       done;

  initial rxd_out = 1'b1;

  function automatic logic pbit(logic [7:0] d);
    return (par_mode == 2'h1) ? ~^d : ^d;
  endfunction

  task automatic put(logic v);
    rxd_out <= v;
    repeat (bit_clks) @(posedge clk_in);
  endtask

  // One-clock spike on the first of the three mid-bit samples; only lands on it when every clock is a tick
  task automatic put_spiked(logic v);
    rxd_out <= v;
    repeat (bit_clks / 2) @(posedge clk_in);
    rxd_out <= ~v;
    @(posedge clk_in);
    rxd_out <= v;
    repeat (bit_clks / 2 - 1) @(posedge clk_in);
  endtask

  // Broken parity or stop only when a scenario asks for it
  task automatic send(logic [7:0] d, logic bad_par, logic bad_stop);
    put(1'b0);
    for (int i = 0; i < 8; i++) begin
      if (spike && i == 0) begin
        put_spiked(d[i]);
      end else begin
        put(d[i]);
      end
    end
    if (par_mode != 2'h0) begin
      put(pbit(d) ^ bad_par);
    end
    put(~bad_stop);
    put(1'b1);
  endtask

  // Bit 8 of got flags a bad start, parity or stop
  initial forever begin
    @(negedge txd_in);
    repeat (bit_clks / 2) @(posedge clk_in);
    got[8] = txd_in;
    for (int i = 0; i < 8; i++) begin
      repeat (bit_clks) @(posedge clk_in);
      got[i] = txd_in;
    end
    if (par_mode != 2'h0) begin
      repeat (bit_clks) @(posedge clk_in);
      got[8] = got[8] | (txd_in ^ pbit(got[7:0]));
    end
    repeat (bit_clks) @(posedge clk_in);
    got[8] = got[8] | !txd_in;
    if (two_stop) begin
      repeat (bit_clks) @(posedge clk_in);
      got[8] = got[8] | !txd_in;
    end
    -> done;
  end
endmodule
`default_nettype wire
